// ### verilog/spau_regs.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module spau_regs (
   // System clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   // AXI4-Lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read address
   input  wire logic [11:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   // AXI4-Lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Serial link clock
   input  wire logic        sclk,
   // External alignment pin, active low
   input  wire logic        align_pin_n,
   // Controls to the clock section
   output logic             align_power_down,
   output logic             dist_ref_power_down,
   output logic             channel_hold,
   output logic             align_event
);

   // ---------------------------------------------------------------
   // System clock state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                 aw_have;
      logic [11:0]          aw_addr;
      logic                 w_have;
      logic [7:0]           w_byte;
      logic                 w_lane0;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      spau_pkg::spau_sys_type buffer;
      spau_pkg::spau_sys_type xfer;
      spau_pkg::spau_sys_type status;
      logic                 upd_pending;
      logic                 requeue;
      logic                 req_tog;
   } spau_axi_type;

   // ---------------------------------------------------------------
   // Link clock state
   // ---------------------------------------------------------------
   typedef struct packed {
      spau_pkg::spau_sys_type active;
      logic                 req_seen;
      logic                 ack_tog;
      logic                 prev_low;
      logic                 hold;
      logic                 event_p;
   } spau_link_type;

   localparam spau_axi_type AXI_RESET = '{
      aw_have:     1'b0,
      aw_addr:     12'h000,
      w_have:      1'b0,
      w_byte:      8'h00,
      w_lane0:     1'b0,
      bvalid:      1'b0,
      bresp:       spau_pkg::RESP_OKAY,
      rvalid:      1'b0,
      rdata:       32'h0000_0000,
      rresp:       spau_pkg::RESP_OKAY,
      buffer:      spau_pkg::SYS_RESET,
      xfer:        spau_pkg::SYS_RESET,
      status:      spau_pkg::SYS_RESET,
      upd_pending: 1'b0,
      requeue:     1'b0,
      req_tog:     1'b0
   };

   localparam spau_link_type LINK_RESET = '{
      active:   spau_pkg::SYS_RESET,
      req_seen: 1'b0,
      ack_tog:  1'b0,
      prev_low: 1'b0,
      hold:     1'b0,
      event_p:  1'b0
   };

   spau_axi_type  a_r;
   spau_axi_type  a_nxt;
   spau_link_type l_r;
   spau_link_type l_nxt;

   logic                             link_rst_n;
   logic                             req_sync;
   logic                             pin_n_sync;
   logic                             ack_sync;
   logic [spau_pkg::SYS_W-1:0]       active_sync;
   logic                             do_write;
   logic                             upd_req;
   logic                             ack_done;
   logic                             align_low;

   // ---------------------------------------------------------------
   // Crossings
   // ---------------------------------------------------------------
   spau_sync #(.W(1)) u_rst_sync (
      .clk (sclk),
      .d   (aresetn),
      .q   (link_rst_n)
   );

   spau_sync #(.W(2)) u_to_link (
      .clk (sclk),
      .d   ({a_r.req_tog, align_pin_n}),
      .q   ({req_sync, pin_n_sync})
   );

   spau_sync #(.W(1)) u_ack_sync (
      .clk (aclk),
      .d   (l_r.ack_tog),
      .q   (ack_sync)
   );

   // Status word only taken once the transfer is acknowledged
   spau_sync #(.W(spau_pkg::SYS_W)) u_stat_sync (
      .clk (aclk),
      .d   (l_r.active),
      .q   (active_sync)
   );

   // ---------------------------------------------------------------
   // Bus handshakes
   // ---------------------------------------------------------------
   assign awready = !a_r.aw_have && !a_r.bvalid;
   assign wready  = !a_r.w_have && !a_r.bvalid;
   assign arready = !a_r.rvalid;
   assign bvalid  = a_r.bvalid;
   assign bresp   = a_r.bresp;
   assign rvalid  = a_r.rvalid;
   assign rdata   = a_r.rdata;
   assign rresp   = a_r.rresp;

   assign do_write = a_r.aw_have && a_r.w_have && !a_r.bvalid;
   assign ack_done = a_r.upd_pending && (ack_sync == a_r.req_tog);

   // ---------------------------------------------------------------
   // System clock next state
   // ---------------------------------------------------------------
   always_comb begin
      a_nxt   = a_r;
      upd_req = 1'b0;

      if (awvalid && awready) begin
         a_nxt.aw_have = 1'b1;
         a_nxt.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         a_nxt.w_have  = 1'b1;
         a_nxt.w_byte  = wdata[7:0];
         a_nxt.w_lane0 = wstrb[0];
      end
      if (a_r.bvalid && bready) begin
         a_nxt.bvalid = 1'b0;
      end

      // Register write once both halves are in
      if (do_write) begin
         a_nxt.aw_have = 1'b0;
         a_nxt.w_have  = 1'b0;
         a_nxt.bvalid  = 1'b1;
         a_nxt.bresp   = spau_pkg::RESP_OKAY;
         unique case (a_r.aw_addr)
            spau_pkg::SYS_ADDR: begin
               if (a_r.w_lane0) begin
                  a_nxt.buffer = a_r.w_byte[spau_pkg::SYS_W-1:0];
               end
            end
            spau_pkg::UPD_ADDR: begin
               upd_req = a_r.w_lane0 && a_r.w_byte[spau_pkg::UPDATE_BIT];
            end
            spau_pkg::STAT_ADDR: begin
               a_nxt.bresp = spau_pkg::RESP_OKAY;
            end
            default: begin
               a_nxt.bresp = spau_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Self-clearing update request, set beats clear
      if (ack_done) begin
         a_nxt.upd_pending = 1'b0;
         a_nxt.status      = active_sync;
      end
      if (upd_req || a_r.requeue) begin
         if (a_r.upd_pending && !ack_done) begin
            a_nxt.requeue = 1'b1;
         end else begin
            a_nxt.upd_pending = 1'b1;
            a_nxt.requeue     = 1'b0;
            a_nxt.xfer        = a_nxt.buffer;
            a_nxt.req_tog     = !a_r.req_tog;
         end
      end

      // Read channel
      if (a_r.rvalid && rready) begin
         a_nxt.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         a_nxt.rvalid = 1'b1;
         a_nxt.rresp  = spau_pkg::RESP_OKAY;
         unique case (araddr)
            spau_pkg::SYS_ADDR: begin
               a_nxt.rdata = {29'h0000_0000, a_r.buffer};
            end
            spau_pkg::UPD_ADDR: begin
               a_nxt.rdata = {31'h0000_0000,
                              a_r.upd_pending || a_r.requeue};
            end
            spau_pkg::STAT_ADDR: begin
               a_nxt.rdata = {29'h0000_0000, a_r.status};
            end
            default: begin
               a_nxt.rdata = 32'h0000_0000;
               a_nxt.rresp = spau_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_r <= AXI_RESET;
      end else begin
         a_r <= a_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Link clock next state
   // ---------------------------------------------------------------
   // Soft bit high acts as the pin pulled low
   assign align_low = l_r.active.soft_align || !pin_n_sync;

   always_comb begin
      l_nxt = l_r;

      // Snapshot is stable while the request toggle is unanswered
      if (req_sync != l_r.req_seen) begin
         l_nxt.active   = a_r.xfer;
         l_nxt.req_seen = req_sync;
      end
      l_nxt.ack_tog = l_r.req_seen;

      l_nxt.prev_low = align_low && !l_r.active.align_pd;
      l_nxt.hold     = align_low && !l_r.active.align_pd;
      l_nxt.event_p  = l_r.prev_low && !align_low
                       && !l_r.active.align_pd;
   end

   always_ff @(posedge sclk) begin
      if (!link_rst_n) begin
         l_r <= LINK_RESET;
      end else begin
         l_r <= l_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs to the clock section
   // ---------------------------------------------------------------
   assign align_power_down    = l_r.active.align_pd;
   assign dist_ref_power_down = l_r.active.ref_pd;
   assign channel_hold        = l_r.hold;
   assign align_event         = l_r.event_p;

endmodule

// ### verilog/spau_pkg.sv
package spau_pkg;

   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam int          ADDR_W     = 12;
   localparam logic [11:0] SYS_IDX    = 12'h230;
   localparam logic [11:0] UPD_IDX    = 12'h232;
   localparam logic [11:0] STAT_IDX   = 12'h233;
   localparam logic [11:0] SYS_ADDR   = {SYS_IDX[9:0], 2'h0};
   localparam logic [11:0] UPD_ADDR   = {UPD_IDX[9:0], 2'h0};
   localparam logic [11:0] STAT_ADDR  = {STAT_IDX[9:0], 2'h0};

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          ALIGN_PD_BIT   = 2;
   localparam int          REF_PD_BIT     = 1;
   localparam int          SOFT_ALIGN_BIT = 0;
   localparam int          UPDATE_BIT     = 0;
   localparam int          SYS_W          = 3;

   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // System control fields, reset all clear
   // ---------------------------------------------------------------
   typedef struct packed {
      logic align_pd;
      logic ref_pd;
      logic soft_align;
   } spau_sys_type;

   localparam spau_sys_type SYS_RESET = '{align_pd: 1'b0, ref_pd: 1'b0,
                                           soft_align: 1'b0};

endpackage

// ### verilog/spau_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Two-stage synchroniser
// ------------------------------------------------------------------
module spau_sync #(
   parameter int W = 1
) (
   // Destination clock
   input  wire logic         clk,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stage;
   } spau_sync_type;

   spau_sync_type s_r;
   spau_sync_type s_nxt;

   always_comb begin
      s_nxt       = s_r;
      s_nxt.meta  = d;
      s_nxt.stage = s_r.meta;
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   assign q = s_r.stage;

endmodule

// ### testbench/spau_regs_asserts.sv
`timescale 1ns/1ps
module spau_regs_asserts (
   // Clocks and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        sclk,
   // Bus handshakes
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   // Link side
   input wire logic        align_pin_n,
   input wire logic        align_power_down,
   input wire logic        channel_hold,
   input wire logic        align_event
);
   // ---------------------------------------------------------------
   // Link side
   // ---------------------------------------------------------------
   sequence pin_low_s;
      (!align_pin_n && !align_power_down) [*5];
   endsequence

   chk_pd_quiet: assert property (
      @(posedge sclk) disable iff (!aresetn)
      align_power_down [*3] |-> !channel_hold && !align_event)
      else $error("hold or event while powered down");
   chk_pin_hold: assert property (
      @(posedge sclk) disable iff (!aresetn)
      pin_low_s |-> channel_hold)
      else $error("pin low without channel hold");
   chk_event_pulse: assert property (
      @(posedge sclk) disable iff (!aresetn)
      align_event |=> !align_event)
      else $error("alignment event longer than one cycle");
   chk_event_cause: assert property (
      @(posedge sclk) disable iff (!aresetn)
      $rose(align_event) |->
         !channel_hold && ($past(channel_hold) || $past(channel_hold, 2)))
      else $error("alignment event without hold release");
   // ---------------------------------------------------------------
   // Bus side
   // ---------------------------------------------------------------
   sequence both_taken_s;
      awvalid && awready && wvalid && wready;
   endsequence

   chk_b_late: assert property (
      @(posedge aclk) disable iff (!aresetn)
      both_taken_s |-> ##[1:3] bvalid)
      else $error("write response late");
   chk_b_block: assert property (
      @(posedge aclk) disable iff (!aresetn)
      bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   chk_r_late: assert property (
      @(posedge aclk) disable iff (!aresetn)
      arvalid && arready |=> rvalid)
      else $error("read data late");
   chk_r_block: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rvalid |-> !arready)
      else $error("read taken while data pending");
endmodule

bind spau_regs spau_regs_asserts i_chk (.aclk, .aresetn, .sclk, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid,
   .align_pin_n, .align_power_down, .channel_hold, .align_event);

// ### testbench/spau_link_model.sv
`timescale 1ns/1ps
module spau_link_model (
   // Request from bench
   input wire logic       pin_low,
   // Link side
   input wire logic       align_event,
   output logic           sclk,
   output logic           align_pin_n,
   output logic [7:0]     n_events
);
   // ---------------------------------------------------------------
   // Free link clock, pin moved just after a link edge
   // ---------------------------------------------------------------
   initial begin
      sclk = 1'b0;
      align_pin_n = 1'b1;
      n_events = 8'h0;
      #7;
      forever #40 sclk = ~sclk;
   end
   always @(posedge sclk) begin
      align_pin_n <= ~pin_low;
      if (align_event) begin
         n_events <= n_events + 8'h1;
      end
   end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        aclk, sclk, align_pin_n, awready, wready, bvalid;
   logic        arready, rvalid, align_event, channel_hold;
   logic        align_power_down, dist_ref_power_down;
   logic        aresetn = 1'b0, pin_low = 1'b0, awvalid = 1'b0;
   logic        wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0]  wstrb = 4'h1;
   logic [2:0]  awprot = 3'h0, arprot = 3'h0;
   logic [1:0]  bresp, rresp, rr;
   logic [7:0]  n_events, ev0;
   int          n_errors = 0, checks_done = 0, cyc = 0;

   spau_regs i_dut (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .awaddr              (awaddr),
      .awprot              (awprot),
      .awvalid             (awvalid),
      .awready             (awready),
      .wdata               (wdata),
      .wstrb               (wstrb),
      .wvalid              (wvalid),
      .wready              (wready),
      .bresp               (bresp),
      .bvalid              (bvalid),
      .bready              (bready),
      .araddr              (araddr),
      .arprot              (arprot),
      .arvalid             (arvalid),
      .arready             (arready),
      .rdata               (rdata),
      .rresp               (rresp),
      .rvalid              (rvalid),
      .rready              (rready),
      .sclk                (sclk),
      .align_pin_n         (align_pin_n),
      .align_power_down    (align_power_down),
      .dist_ref_power_down (dist_ref_power_down),
      .channel_hold        (channel_hold),
      .align_event         (align_event)
   );
   spau_link_model i_link (.pin_low(pin_low), .align_event(align_event),
      .sclk(sclk), .align_pin_n(align_pin_n), .n_events(n_events));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         final_report();
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge aclk);
         ad = ad || awready;
         wd = wd || wready;
         @(posedge aclk);
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      axi_rd(a, rd, rr);
      chk(rd, e);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      axi_wr(a, d, rr);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task automatic sw(input int n);
      repeat (n) @(posedge sclk);
      @(negedge sclk);
   endtask
   task automatic update();
      int n;
      n = 0;
      wrc(spau_pkg::UPD_ADDR, 32'h1, spau_pkg::RESP_OKAY);
      do begin
         axi_rd(spau_pkg::UPD_ADDR, rd, rr);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      chk(rd, 32'h0);
      sw(3);
   endtask
   task automatic pin(input logic v);
      @(posedge aclk);
      pin_low <= v;
      sw(8);
   endtask
   task automatic lk(input logic [31:0] e);
      chk({29'h0, align_power_down, dist_ref_power_down, channel_hold}, e);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge sclk);
      @(posedge aclk);
      aresetn <= 1'b1;
      rdc(spau_pkg::SYS_ADDR, 32'h0, spau_pkg::RESP_OKAY);
      rdc(spau_pkg::UPD_ADDR, 32'h0, spau_pkg::RESP_OKAY);
      wrc(spau_pkg::SYS_ADDR, 32'h6, spau_pkg::RESP_OKAY);
      sw(8);
      lk(32'h0);
      update();
      lk(32'h6);
      rdc(spau_pkg::STAT_ADDR, 32'h6, spau_pkg::RESP_OKAY);
      ev0 = n_events;
      pin(1'b1);
      lk(32'h6);
      pin(1'b0);
      chk({24'h0, n_events - ev0}, 32'h0);
      wrc(spau_pkg::SYS_ADDR, 32'h1, spau_pkg::RESP_OKAY);
      update();
      lk(32'h1);
      wrc(spau_pkg::SYS_ADDR, 32'h0, spau_pkg::RESP_OKAY);
      update();
      chk({24'h0, n_events - ev0}, 32'h1);
      lk(32'h0);
      pin(1'b1);
      lk(32'h1);
      pin(1'b0);
      chk({24'h0, n_events - ev0}, 32'h2);
      rdc(12'h010, 32'h0, spau_pkg::RESP_SLVERR);
      wrc(12'h010, 32'h7, spau_pkg::RESP_SLVERR);
      wrc(spau_pkg::STAT_ADDR, 32'h7, spau_pkg::RESP_OKAY);
      rdc(spau_pkg::STAT_ADDR, 32'h0, spau_pkg::RESP_OKAY);
      rdc(spau_pkg::SYS_ADDR, 32'h0, spau_pkg::RESP_OKAY);
      // Write with byte lane 0 disabled leaves the buffer alone
      @(posedge aclk);
      wstrb <= 4'h0;
      wrc(spau_pkg::SYS_ADDR, 32'h7, spau_pkg::RESP_OKAY);
      @(posedge aclk);
      wstrb <= 4'h1;
      rdc(spau_pkg::SYS_ADDR, 32'h0, spau_pkg::RESP_OKAY);
      // Update while one is pending is queued with the newer buffer
      wrc(spau_pkg::SYS_ADDR, 32'h2, spau_pkg::RESP_OKAY);
      wrc(spau_pkg::UPD_ADDR, 32'h1, spau_pkg::RESP_OKAY);
      wrc(spau_pkg::SYS_ADDR, 32'h4, spau_pkg::RESP_OKAY);
      rdc(spau_pkg::UPD_ADDR, 32'h1, spau_pkg::RESP_OKAY);
      update();
      lk(32'h4);
      rdc(spau_pkg::STAT_ADDR, 32'h4, spau_pkg::RESP_OKAY);
      final_report();
   end
endmodule
